// ### img_cfg_bank.sv
// configuration register bank with axi4-lite slave and decoded settings
// assumes one clock, synchronous active-low reset, one access at a time
//
// Our own choices: the AXI4-Lite slave port and the address map.
`include "img_cfg_consts.svh"
`default_nettype none
module img_cfg_bank #(
  parameter int POS_W = 15,
  parameter int TBL_AW = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output img_cfg_pkg::bin_mode_t bin_mode,
  output logic [2:0] char_enh_level,
  output logic [15:0] clamp_start_px,
  output logic [15:0] clamp_end_px,
  output logic [15:0] corr_start_px,
  output logic [19:0] track_start_px,
  output logic [19:0] track_end_px
);
  import img_cfg_pkg::*;
  // ***********************************************************************
  // registers
  // ***********************************************************************
  logic [31:0] ctrl_q, ctrl_d, clamp_q, clamp_d, corr_q, corr_d;
  logic [31:0] track_q, track_d;
  logic [TBL_AW-1:0] taddr_q, taddr_d;
  logic tsel_q, tsel_d;
  wr_state_t wst_q, wst_d;
  logic [3:0] awidx_q, awidx_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [31:0] wdat_q, wdat_d;
  logic [3:0] wstb_q, wstb_d;
  logic [1:0] bresp_q, bresp_d;
  logic rv_q, rv_d, rpend_q, rpend_d, rmem_q, rmem_d;
  logic [31:0] rdat_q, rdat_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] mem_rd;
  logic mem_we, do_wr;
  logic [3:0] aridx;
  logic [15:0] cfg_out_q [0:2];
  logic [19:0] trk_out_q [0:1];
  bin_mode_t mode_q;
  logic [2:0] ce_q;
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] stb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (stb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
  function automatic logic mapped(input logic [3:0] idx);
    return (idx <= `IDX_STATUS) || (idx == `IDX_DATA);
  endfunction
  // ***********************************************************************
  // write channel: address and data taken in either order
  // ***********************************************************************
  assign s_axi_awready = !aw_have_q && (wst_q == WR_IDLE);
  assign s_axi_wready = !w_have_q && (wst_q == WR_IDLE);
  assign do_wr = aw_have_q && w_have_q && (wst_q == WR_IDLE);
  assign mem_we = do_wr && (awidx_q == `IDX_DATA);
  assign aridx = s_axi_araddr[5:2];
  always_comb
  begin
    ctrl_d = ctrl_q;
    clamp_d = clamp_q;
    corr_d = corr_q;
    track_d = track_q;
    taddr_d = taddr_q;
    tsel_d = tsel_q;
    wst_d = wst_q;
    awidx_d = awidx_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    wdat_d = wdat_q;
    wstb_d = wstb_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awidx_d = s_axi_awaddr[5:2];
      aw_have_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wdat_d = s_axi_wdata;
      wstb_d = s_axi_wstrb;
      w_have_d = 1'b1;
    end
    unique case (wst_q)
      WR_IDLE:
      begin
        if (do_wr)
        begin
          aw_have_d = 1'b0;
          w_have_d = 1'b0;
          wst_d = WR_RESP;
          bresp_d = mapped(awidx_q) ? `RESP_OKAY : `RESP_SLVERR;
          unique case (awidx_q)
            `IDX_CTRL: ctrl_d = merge(ctrl_q, wdat_q, wstb_q);
            `IDX_CLAMP: clamp_d = merge(clamp_q, wdat_q, wstb_q);
            `IDX_CORR: corr_d = merge(corr_q, wdat_q, wstb_q);
            `IDX_TRACK: track_d = merge(track_q, wdat_q, wstb_q);
            `IDX_TBL_ADDR:
            begin
              taddr_d = wdat_q[TBL_AW-1:0];
              tsel_d = wdat_q[`F_SEL_BIT];
            end
            // each data-port access walks the table pointer
            `IDX_DATA: taddr_d = taddr_q + 1'b1;
            default: ;
          endcase
        end
      end
      WR_RESP:
      begin
        if (s_axi_bready)
        begin
          wst_d = WR_IDLE;
        end
      end
      default: wst_d = WR_IDLE;
    endcase
    if (rpend_q && rmem_q)
    begin
      taddr_d = taddr_d + 1'b1;
    end
    if (!rst_n)
    begin
      ctrl_d = `ZERO32;
      clamp_d = `ZERO32;
      corr_d = `ZERO32;
      track_d = track_q;
      taddr_d = taddr_q;
      tsel_d = tsel_q;
      wst_d = WR_IDLE;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    ctrl_q <= ctrl_d;
    clamp_q <= clamp_d;
    corr_q <= corr_d;
    track_q <= track_d;
    taddr_q <= taddr_d;
    tsel_q <= tsel_d;
    wst_q <= wst_d;
    awidx_q <= awidx_d;
    aw_have_q <= aw_have_d;
    w_have_q <= w_have_d;
    wdat_q <= wdat_d;
    wstb_q <= wstb_d;
    bresp_q <= bresp_d;
  end

  assign s_axi_bvalid = (wst_q == WR_RESP);
  assign s_axi_bresp = bresp_q;
  // ***********************************************************************
  // read channel; data-port reads wait one cycle for the memory
  // ***********************************************************************
  assign s_axi_arready = !rv_q && !rpend_q;
  always_comb
  begin
    rv_d = rv_q;
    rpend_d = 1'b0;
    rmem_d = 1'b0;
    rdat_d = rdat_q;
    rresp_d = rresp_q;
    if (rv_q && s_axi_rready)
    begin
      rv_d = 1'b0;
    end
    if (rpend_q)
    begin
      rv_d = 1'b1;
      rdat_d = rmem_q ? mem_rd : rdat_q;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rpend_d = 1'b1;
      rmem_d = (aridx == `IDX_DATA);
      rresp_d = mapped(aridx) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (aridx)
        `IDX_CTRL: rdat_d = ctrl_q;
        `IDX_CLAMP: rdat_d = clamp_q;
        `IDX_CORR: rdat_d = corr_q;
        `IDX_TRACK: rdat_d = track_q;
        `IDX_TBL_ADDR: rdat_d = {23'h0, tsel_q, {(8-TBL_AW){1'b0}}, taddr_q};
        `IDX_STATUS: rdat_d = {27'h0, ce_q, mode_q};
        default: rdat_d = `ZERO32;
      endcase
    end
    if (!rst_n)
    begin
      rv_d = 1'b0;
      rpend_d = 1'b0;
      rmem_d = 1'b0;
      rdat_d = `ZERO32;
      rresp_d = `RESP_OKAY;
    end
  end

  always_ff @(posedge mclk)
  begin
    rv_q <= rv_d;
    rpend_q <= rpend_d;
    rmem_q <= rmem_d;
    rdat_q <= rdat_d;
    rresp_q <= rresp_d;
  end

  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rdat_q;
  assign s_axi_rresp = rresp_q;
  img_cfg_store #(.ADDR_W(TBL_AW)) u_store (
    .mclk(mclk),
    .sel_white(tsel_q),
    .addr(taddr_q),
    .wr_en(mem_we),
    .wr_data(wdat_q),
    .rd_data(mem_rd)
  );
  // ***********************************************************************
  // decoded settings driven to the datapath
  // ***********************************************************************
  bin_mode_t mode_d;
  logic [2:0] ce_d;
  logic [15:0] cfg_d [0:2];
  logic [19:0] trk_d [0:1];
  always_comb
  begin
    unique case (ctrl_q[`F_MODE_LO +: 2])
      2'h2: mode_d = BIN_DITHER;
      2'h3: mode_d = BIN_ERRDISP;
      default: mode_d = BIN_THRESH;
    endcase
    // strength grows with the code; 000 forces off, threshold ignores it
    ce_d = (mode_d == BIN_THRESH) ? 3'h0 : ctrl_q[`F_CE_LO +: 3];
    cfg_d[0] = {1'b0, clamp_q[POS_W-1:0]};
    cfg_d[1] = {1'b0, clamp_q[`F_HI_LO +: POS_W]};
    cfg_d[2] = {1'b0, corr_q[POS_W-1:0]};
    trk_d[0] = {1'b0, track_q[POS_W-1:0], 4'h0};
    trk_d[1] = {1'b0, track_q[`F_HI_LO +: POS_W], 4'h0};
  end

  always_ff @(posedge mclk)
  begin
    mode_q <= mode_d;
    ce_q <= ce_d;
    cfg_out_q <= cfg_d;
    trk_out_q <= trk_d;
  end

  assign bin_mode = mode_q;
  assign char_enh_level = ce_q;
  assign clamp_start_px = cfg_out_q[0];
  assign clamp_end_px = cfg_out_q[1];
  assign corr_start_px = cfg_out_q[2];
  assign track_start_px = trk_out_q[0];
  assign track_end_px = trk_out_q[1];
  // ***********************************************************************
  // checks
  // ***********************************************************************
  property p_ce_off;
    @(posedge mclk) disable iff (!rst_n)
    (ctrl_q[`F_CE_LO +: 3] == 3'h0) |=> (char_enh_level == 3'h0);
  endproperty
  a_ce_off: assert property (p_ce_off) else $error("enh not off");
  property p_ce_dither;
    @(posedge mclk) disable iff (!rst_n)
    (ctrl_q[1:0] == 2'h2) |=> (char_enh_level == $past(ctrl_q[6:4]));
  endproperty
  a_ce_dither: assert property (p_ce_dither) else $error("dither level");
  property p_ce_err;
    @(posedge mclk) disable iff (!rst_n)
    (ctrl_q[1:0] == 2'h3) |=> (char_enh_level == $past(ctrl_q[6:4]));
  endproperty
  a_ce_err: assert property (p_ce_err) else $error("errdisp level");
  property p_mode;
    @(posedge mclk) disable iff (!rst_n)
    (ctrl_q[1] == 1'b0) |=> (bin_mode == BIN_THRESH);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode");
  property p_rst_clear;
    @(posedge mclk) !rst_n |=> (ctrl_q == 32'h0 && clamp_q == 32'h0
      && corr_q == 32'h0);
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("no clear");
  // kept state is unknown until first written, so start at a mid-run reset
  property p_rst_keep;
    @(posedge mclk) (!rst_n && $past(rst_n)) |=> (track_q == $past(track_q));
  endproperty
  a_rst_keep: assert property (p_rst_keep) else $error("kept lost");
  property p_clamp;
    @(posedge mclk) disable iff (!rst_n)
    ##1 (clamp_start_px == {1'b0, $past(clamp_q[14:0])});
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp unit");
  property p_corr;
    @(posedge mclk) disable iff (!rst_n)
    ##1 (corr_start_px == {1'b0, $past(corr_q[14:0])});
  endproperty
  a_corr: assert property (p_corr) else $error("corr unit");
  property p_track;
    @(posedge mclk) disable iff (!rst_n)
    ##1 (track_end_px == {1'b0, $past(track_q[30:16]), 4'h0});
  endproperty
  a_track: assert property (p_track) else $error("track unit");
  sequence s_dread;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[5:2] == `IDX_DATA);
  endsequence
  property p_dread;
    @(posedge mclk) disable iff (!rst_n)
    s_dread |=> ##1 (s_axi_rvalid && s_axi_rdata == $past(mem_rd));
  endproperty
  a_dread: assert property (p_dread) else $error("port read");
endmodule // img_cfg_bank
`default_nettype wire

// ### img_cfg_consts.svh
// constants for the image-processor configuration register bank
// assumes a single clock domain and a 32-bit axi4-lite register bus
//
// Behaviour
// - in dither mode, codes 001 to 111 give enhancement growing with code.
// - in dither mode, code 000 turns character enhancement off.
// - in error-dispersion mode, 000 is off and 001 to 111 grow in strength.
// - reset clears the registers at indices zero through two to zero.
// - reset leaves every other register at its last written value.
// - line-clamp start and end positions count single pixels.
// - the distortion-correction start position counts single pixels.
// - background-tracking window positions count steps of sixteen pixels.
// - white reference data is read and written through index eight.
// - binarization mode 00/01 is threshold, 10 dither, 11 error dispersion.
`ifndef IMG_CFG_CONSTS_SVH
`define IMG_CFG_CONSTS_SVH
// ***********************************************************************
// register indices (byte address is four times the index)
// ***********************************************************************
`define IDX_CTRL 4'h0
`define IDX_CLAMP 4'h1
`define IDX_CORR 4'h2
`define IDX_TRACK 4'h3
`define IDX_TBL_ADDR 4'h4
`define IDX_STATUS 4'h5
`define IDX_DATA 4'h8
`define IDX_LAST 4'h8
// ***********************************************************************
// field positions and misc values
// ***********************************************************************
`define F_MODE_LO 0
`define F_CE_LO 4
`define F_SEL_BIT 8
`define F_LO_HI 15
`define F_HI_LO 16
`define TRACK_SHIFT 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ZERO32 32'h0000_0000
`endif

// ### img_cfg_pkg.sv
// types for the image-processor configuration register bank
// assumes img_cfg_consts.svh is available to the including files
`default_nettype none
package img_cfg_pkg;
  typedef enum logic [1:0] {BIN_THRESH, BIN_DITHER, BIN_ERRDISP} bin_mode_t;
  typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_state_t;
endpackage
`default_nettype wire

// ### img_cfg_store.sv
// data-port storage: table memory and white reference memory
// assumes the bank presents one access per cycle
`default_nettype none
module img_cfg_store #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic sel_white,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data
);
  logic [31:0] table_mem [0:(1<<ADDR_W)-1];
  logic [31:0] white_mem [0:(1<<ADDR_W)-1];
  logic [31:0] rd_d;
  // ***********************************************************************
  // memories; the white path and the table path both read back through rd_data
  // ***********************************************************************
  always_comb
  begin
    rd_d = sel_white ? white_mem[addr] : table_mem[addr];
  end
  always_ff @(posedge mclk)
  begin
    if (wr_en && sel_white)
    begin
      white_mem[addr] <= wr_data;
    end
    if (wr_en && !sel_white)
    begin
      table_mem[addr] <= wr_data;
    end
    rd_data <= rd_d;
  end
endmodule // img_cfg_store
`default_nettype wire

// ### axi_host.sv
// axi4-lite host model driving the configuration register bank
// assumes one clock; tasks are called by the bench between clock edges
`default_nettype none
module axi_host (
  input wire logic mclk,
  output var logic [5:0] s_axi_awaddr,
  output var logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output var logic [31:0] s_axi_wdata,
  output var logic [3:0] s_axi_wstrb,
  output var logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output var logic s_axi_bready,
  output var logic [5:0] s_axi_araddr,
  output var logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output var logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  // ***********************************************************************
  // bus cycles
  // ***********************************************************************
  // handshakes are judged mid-cycle, where the slave's outputs have settled,
  // and acted on at the following rising edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    output logic [1:0] r, input logic [3:0] s = 4'hF);
    logic aw_t, w_t, b_t;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t)
    begin
      @(negedge mclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
      @(posedge mclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t)
    begin
      @(negedge mclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) s_axi_rready <= 1'b0;
    end
  endtask
endmodule // axi_host
`default_nettype wire

// ### tb.sv
// self-checking bench for the configuration register bank
// assumes the host model file and the design files are compiled first
`default_nettype none
module tb;
  import img_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  bin_mode_t bin_mode, em;
  logic [2:0] char_enh_level, el;
  logic [15:0] clamp_start_px, clamp_end_px, corr_start_px;
  logic [19:0] track_start_px, track_end_px;
  int err_total, cmp_count;
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  axi_host host (.mclk(mclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  img_cfg_bank #(.POS_W(15), .TBL_AW(8)) uut (.mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bin_mode(bin_mode),
    .char_enh_level(char_enh_level), .clamp_start_px(clamp_start_px),
    .clamp_end_px(clamp_end_px), .corr_start_px(corr_start_px),
    .track_start_px(track_start_px), .track_end_px(track_end_px));
  // ***********************************************************************
  // helpers
  // ***********************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic reset_pulse();
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // generous: about 100 bus cycles of at most ten clocks each
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    results();
  end
  // ***********************************************************************
  // tests
  // ***********************************************************************
  initial
  begin
    err_total = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      host.rd(6'(4 * i), d, r);
      chk(d, 32'h0000_0000);
    end
    $display("test reset values done");
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 8; c++)
      begin
        em = (m < 2) ? BIN_THRESH : ((m == 2) ? BIN_DITHER : BIN_ERRDISP);
        el = (m < 2) ? 3'h0 : 3'(c);
        host.wr(6'h00, 32'(c * 16 + m), r);
        repeat (2) @(negedge mclk);
        chk(32'(bin_mode), 32'(em));
        chk(32'(char_enh_level), 32'(el));
        host.rd(6'h14, d, r);
        chk(d, 32'(el) * 4 + 32'(em));
      end
    $display("test modes done");
    host.wr(6'h04, 32'h7FFF_0001, r);
    chk(32'(r), 32'h0000_0000);
    host.wr(6'h08, 32'h0000_1234, r);
    host.wr(6'h0C, 32'h7FFF_0003, r);
    repeat (2) @(negedge mclk);
    chk(32'(clamp_start_px), 32'h0000_0001);
    chk(32'(clamp_end_px), 32'h0000_7FFF);
    chk(32'(corr_start_px), 32'h0000_1234);
    chk(32'(track_start_px), 32'h0000_0030);
    chk(32'(track_end_px), 32'h0007_FFF0);
    // only the low byte lane is enabled: the rest of the word must stay
    host.wr(6'h08, 32'hFFFF_ABCD, r, 4'h1);
    @(negedge mclk);
    chk(32'(corr_start_px), 32'h0000_12CD);
    $display("test positions done");
    // both stores share one port: distinct patterns show they do not alias
    for (int s = 0; s < 2; s++)
    begin
      host.wr(6'h10, 32'(s * 256), r);
      for (int k = 0; k < 3; k++)
        host.wr(6'h20, 32'h5A00_0000 + 32'(s * 16 + k), r);
    end
    for (int s = 0; s < 2; s++)
    begin
      host.wr(6'h10, 32'(s * 256), r);
      for (int k = 0; k < 3; k++)
      begin
        host.rd(6'h20, d, r);
        chk(d, 32'h5A00_0000 + 32'(s * 16 + k));
      end
    end
    $display("test data port done");
    host.wr(6'h18, 32'hFFFF_FFFF, r);
    chk(32'(r), 32'h0000_0002);
    host.rd(6'h18, d, r);
    chk(d, 32'h0000_0000);
    chk(32'(r), 32'h0000_0002);
    $display("test unmapped done");
    host.wr(6'h10, 32'h0000_0100, r);
    reset_pulse();
    for (int i = 0; i < 3; i++)
    begin
      host.rd(6'(4 * i), d, r);
      chk(d, 32'h0000_0000);
    end
    host.rd(6'h0C, d, r);
    chk(d, 32'h7FFF_0003);
    chk(32'(track_start_px), 32'h0000_0030);
    host.rd(6'h10, d, r);
    chk(d, 32'h0000_0100);
    host.rd(6'h20, d, r);
    chk(d, 32'h5A00_0010);
    $display("test reset retention done");
    results();
  end
endmodule // tb
`default_nettype wire
